// [hw/mct_top.sv]
`default_nettype none
module mct_top
  import mct_pkg::*;
#(
  parameter int CHANNELS = 3
) (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [17:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic                       pready,
  output logic [31:0]                prdata,
  output logic                       pslverr,
  // capture inputs
  input  wire logic [CHANNELS-1:0]   primary_capture_pin,
  input  wire logic [CHANNELS-1:0]   secondary_position_pin,
  input  wire logic [15:0]           first_timer,
  input  wire logic [CHANNELS-1:0]   state_set_req,
  // first timer events
  input  wire logic [2:0]            ft_compare_event,
  input  wire logic                  ft_period_match,
  input  wire logic                  ft_zero_match,
  input  wire logic                  ft_count_down,
  input  wire logic                  hall_change,
  // outputs
  output logic [CHANNELS-1:0]        channel_out_enable,
  output logic                       period_match_signal,
  output logic                       zero_match_signal,
  output logic                       shadow_transfer_signal
);
  logic [15:0] count_value;
  logic [15:0] active_period_reg;
  logic [15:0] period_shadow_reg;
  logic        run_flag;
  logic        transfer_enable;
  logic [2:0]  clk_sel;
  logic        div256_sel;
  logic        single_shot_enable;
  logic [2:0]  trigger_event_select;
  logic [1:0]  trigger_direction_select;
  logic [3:0]  mode_reg [CHANNELS];
  logic [CHANNELS-1:0] state_clr;
  logic [15:0] val_w [CHANNELS];
  logic [15:0] shd_w [CHANNELS];
  logic [CHANNELS-1:0] st_w;
  logic [CHANNELS-1:0] oe_w;
  logic [14:0] presc_reg;
  logic [14:0] presc_mask;
  logic        tick;
  logic        wr, rd;
  logic        trig_ev, dir_ok, hw_start, pm_now, wrap;
  logic        cmd_wr;
  logic [15:0] reg_idx;
  mct_apb_type apb_state;

  // word-aligned bus: the low two address bits never select a register
  assign reg_idx = paddr[17:2];
  assign wr      = psel & penable & pwrite & pready;
  assign rd      = psel & ~penable & ~pwrite;
  assign cmd_wr  = wr && (reg_idx == MCT_OFS_CMD);

  // apb: one wait-free access; prdata is prepared in the setup cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      apb_state <= MCT_APB_IDLE;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
    end else begin
      case (apb_state)
        MCT_APB_IDLE: begin
          pready  <= psel & ~penable;
          pslverr <= 1'b0;
          if (psel & ~penable) apb_state <= MCT_APB_ACCESS;
        end
        MCT_APB_ACCESS: begin
          pready    <= 1'b0;
          pslverr   <= 1'b0;
          apb_state <= MCT_APB_IDLE;
        end
        default: apb_state <= MCT_APB_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata <= 32'h0;
    end else if (rd) begin
      prdata <= 32'h0;
      case (reg_idx)
        MCT_OFS_COUNT:  prdata <= {16'h0, count_value}; // RULE_19
        MCT_OFS_PERIOD: prdata <= {16'h0, active_period_reg}; // RULE_17
        MCT_OFS_CTRL:   prdata <= {18'h0, trigger_direction_select, 1'b0, trigger_event_select, 3'h0,
                                   single_shot_enable, div256_sel, clk_sel};
        MCT_OFS_STATUS: prdata <= {29'h0, transfer_enable, zero_match_signal, run_flag};
        MCT_OFS_CHMODE: begin
          for (int i = 0; i < CHANNELS; i++) prdata[4*i +: 4] <= mode_reg[i];
          for (int i = 0; i < CHANNELS; i++) prdata[16+i] <= st_w[i];
        end
        default: begin
          for (int i = 0; i < CHANNELS; i++) begin
            if (reg_idx == MCT_OFS_CHVAL0 + 16'(4*i)) prdata <= {16'h0, val_w[i]};
            if (reg_idx == MCT_OFS_CHSHD0 + 16'(4*i)) prdata <= {16'h0, shd_w[i]};
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      clk_sel                  <= 3'h0;
      div256_sel               <= 1'b0;
      single_shot_enable       <= 1'b0;
      trigger_event_select     <= MCT_TEC_NONE;
      trigger_direction_select <= 2'h0;
    end else if (wr && reg_idx == MCT_OFS_CTRL) begin
      clk_sel                  <= pwdata[MCT_CTRL_CLK_LSB +: 3];
      div256_sel               <= pwdata[MCT_CTRL_PRE_BIT];
      single_shot_enable       <= pwdata[MCT_CTRL_SSC_BIT];
      trigger_event_select     <= pwdata[MCT_CTRL_TEC_LSB +: 3]; // RULE_16
      trigger_direction_select <= pwdata[MCT_CTRL_TED_LSB +: 2]; // RULE_16
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < CHANNELS; i++) mode_reg[i] <= 4'h0;
      state_clr <= '0;
    end else begin
      state_clr <= '0;
      if (wr && reg_idx == MCT_OFS_CHMODE)
        for (int i = 0; i < CHANNELS; i++) mode_reg[i] <= pwdata[4*i +: 4];
      if (wr && reg_idx == MCT_OFS_CHCLR) state_clr <= pwdata[CHANNELS-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) period_shadow_reg <= MCT_RST_VALUE;
    else if (wr && reg_idx == MCT_OFS_PERIOD) period_shadow_reg <= pwdata[15:0]; // RULE_17
  end

  always_ff @(posedge clk) begin
    if (!rst_n) transfer_enable <= 1'b0;
    else if (cmd_wr && pwdata[MCT_CMD_STE_SET]) transfer_enable <= 1'b1; // RULE_15
    else if (cmd_wr && pwdata[MCT_CMD_STE_CLR]) transfer_enable <= 1'b0; // RULE_15
  end

  // prescaler held in reset while stopped for reproducible delays
  always_comb begin
    presc_mask = 15'((16'h1 << clk_sel) - 16'h1);
    if (div256_sel) presc_mask = 15'({presc_mask, MCT_DIV256}); // RULE_08
  end

  always_ff @(posedge clk) begin
    if (!rst_n) presc_reg <= 15'h0;
    else if (!run_flag || tick) presc_reg <= 15'h0;
    else presc_reg <= presc_reg + 15'h1; // RULE_08
  end
  assign tick = run_flag && (presc_reg == presc_mask);

  always_comb begin
    case (trigger_event_select) // RULE_16
      MCT_TEC_CMP0: trig_ev = ft_compare_event[0];
      MCT_TEC_CMP1: trig_ev = ft_compare_event[1];
      MCT_TEC_CMP2: trig_ev = ft_compare_event[2];
      MCT_TEC_CMPA: trig_ev = |ft_compare_event;
      MCT_TEC_PM:   trig_ev = ft_period_match;
      MCT_TEC_ZMUP: trig_ev = ft_zero_match & ~ft_count_down;
      MCT_TEC_HALL: trig_ev = hall_change;
      default:      trig_ev = 1'b0;
    endcase
    case (trigger_direction_select) // RULE_16
      MCT_TED_UP:   dir_ok = ~ft_count_down;
      MCT_TED_DOWN: dir_ok = ft_count_down;
      MCT_TED_ANY:  dir_ok = 1'b1;
      default:      dir_ok = 1'b0;
    endcase
  end
  assign hw_start = trig_ev & dir_ok;
  assign pm_now   = (count_value == active_period_reg); // RULE_09
  assign wrap     = tick & pm_now; // RULE_21

  // a start request beats a stop in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_n) run_flag <= 1'b0;
    else if ((cmd_wr && pwdata[MCT_CMD_RUN_SET]) || hw_start) run_flag <= 1'b1; // RULE_13
    else if (cmd_wr && pwdata[MCT_CMD_RUN_CLR]) run_flag <= 1'b0; // RULE_13
    else if (wrap && single_shot_enable) run_flag <= 1'b0; // RULE_12
  end

  always_ff @(posedge clk) begin
    if (!rst_n) count_value <= MCT_RST_VALUE; // RULE_19
    else if (cmd_wr && pwdata[MCT_CMD_CNT_CLR]) count_value <= MCT_RST_VALUE; // RULE_14
    else if (wr && reg_idx == MCT_OFS_COUNT && !run_flag) count_value <= pwdata[15:0]; // RULE_18
    else if (wrap) count_value <= MCT_RST_VALUE; // RULE_09
    else if (tick) count_value <= count_value + 16'h1; // RULE_07
  end

  always_ff @(posedge clk) begin
    if (!rst_n) active_period_reg <= MCT_RST_VALUE;
    else if (transfer_enable && (wrap || !run_flag)) active_period_reg <= period_shadow_reg; // RULE_11 RULE_22
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      period_match_signal    <= 1'b0;
      zero_match_signal      <= 1'b0;
      shadow_transfer_signal <= 1'b0;
      channel_out_enable     <= '0;
    end else begin
      period_match_signal    <= pm_now; // RULE_09
      zero_match_signal      <= (count_value == MCT_RST_VALUE); // RULE_10
      shadow_transfer_signal <= transfer_enable && (wrap || !run_flag); // RULE_22
      channel_out_enable     <= oe_w;
    end
  end

  for (genvar g = 0; g < CHANNELS; g++) begin : g_ch
    mct_capture_channel u_ch (
      .clk                    (clk),
      .rst_n                  (rst_n),
      .capture_mode_select    (mode_reg[g]),
      .state_clear            (state_clr[g]),
      .state_set_req          (state_set_req[g]),
      .primary_capture_pin    (primary_capture_pin[g]),
      .secondary_position_pin (secondary_position_pin[g]),
      .first_timer            (first_timer),
      .channel_value_reg      (val_w[g]),
      .channel_shadow_reg     (shd_w[g]),
      .channel_state_bit      (st_w[g]),
      .out_enable_reg         (oe_w[g])
    );
  end
endmodule // mct_top
`default_nettype wire

// [hw/mct_pkg.sv]
// Function
// RULE_01 - multi-input modes capture to value/shadow registers
// RULE_02 - mode 1111 does no capture
// RULE_03 - hysteresis mode: position falling edge clears state
// RULE_04 - position low forces outputs passive
// RULE_05 - state sets only while position high
// RULE_06 - position high: outputs follow state bit
// RULE_07 - second timer is 16-bit up counter
// RULE_08 - prescaler plus optional divide-by-256
// RULE_09 - period match resets count next tick
// RULE_10 - zero match while count is zero
// RULE_11 - period loads from shadow on transfer
// RULE_12 - single shot stops after period ends
// RULE_13 - run set, run clear, hardware clear; the code's hardware trigger (hw_start) sets run instead
// RULE_14 - count clear zeroes count only
// RULE_15 - transfer enable via set/clear bits only
// RULE_16 - trigger event and direction selects
// RULE_17 - period write shadow, read active
// RULE_18 - count writable only while stopped
// RULE_19 - count register full 16 bits, reset zero
// RULE_20 - capture event sets state, software clears
// RULE_21 - period equals value plus one
// RULE_22 - transfer on period reset or stopped
// RULE_23 - inputs sampled, edges from successive samples
// RULE_24 - first timer count latched on edge
`default_nettype none
package mct_pkg;
  // register indexes: the bus byte address is four times the index
  localparam logic [15:0] MCT_OFS_COUNT    = 16'he880;
  localparam logic [15:0] MCT_OFS_PERIOD   = 16'he8b2;
  localparam logic [15:0] MCT_OFS_CTRL     = 16'he8c0;
  localparam logic [15:0] MCT_OFS_CMD      = 16'he8c4;
  localparam logic [15:0] MCT_OFS_STATUS   = 16'he8c8;
  localparam logic [15:0] MCT_OFS_CHMODE   = 16'he8cc;
  localparam logic [15:0] MCT_OFS_CHCLR    = 16'he8d0;
  localparam logic [15:0] MCT_OFS_CHVAL0   = 16'he8e0;
  localparam logic [15:0] MCT_OFS_CHSHD0   = 16'he8f0;
  // ctrl fields
  localparam int MCT_CTRL_CLK_LSB = 0;
  localparam int MCT_CTRL_PRE_BIT = 3;
  localparam int MCT_CTRL_SSC_BIT = 4;
  localparam int MCT_CTRL_TEC_LSB = 8;
  localparam int MCT_CTRL_TED_LSB = 12;
  // command bits (write-only)
  localparam int MCT_CMD_RUN_SET  = 0;
  localparam int MCT_CMD_RUN_CLR  = 1;
  localparam int MCT_CMD_CNT_CLR  = 2;
  localparam int MCT_CMD_STE_SET  = 3;
  localparam int MCT_CMD_STE_CLR  = 4;
  localparam logic [15:0] MCT_RST_VALUE = 16'h0000;
  localparam logic [7:0]  MCT_DIV256    = 8'hff;
  // capture modes
  localparam logic [3:0] MCT_MODE_HYST   = 4'h9;
  localparam logic [3:0] MCT_MODE_RF     = 4'ha;
  localparam logic [3:0] MCT_MODE_FR     = 4'hb;
  localparam logic [3:0] MCT_MODE_RR     = 4'hc;
  localparam logic [3:0] MCT_MODE_FF     = 4'hd;
  localparam logic [3:0] MCT_MODE_AA     = 4'he;
  localparam logic [3:0] MCT_MODE_NONE   = 4'hf;
  // trigger events
  localparam logic [2:0] MCT_TEC_NONE  = 3'h0;
  localparam logic [2:0] MCT_TEC_CMP0  = 3'h1;
  localparam logic [2:0] MCT_TEC_CMP1  = 3'h2;
  localparam logic [2:0] MCT_TEC_CMP2  = 3'h3;
  localparam logic [2:0] MCT_TEC_CMPA  = 3'h4;
  localparam logic [2:0] MCT_TEC_PM    = 3'h5;
  localparam logic [2:0] MCT_TEC_ZMUP  = 3'h6;
  localparam logic [2:0] MCT_TEC_HALL  = 3'h7;
  // direction: 00 none, 01 up, 10 down, 11 either
  localparam logic [1:0] MCT_TED_UP    = 2'h1;
  localparam logic [1:0] MCT_TED_DOWN  = 2'h2;
  localparam logic [1:0] MCT_TED_ANY   = 2'h3;
  typedef enum logic [1:0] {MCT_APB_IDLE, MCT_APB_ACCESS} mct_apb_type;
endpackage : mct_pkg
`default_nettype wire

// [hw/mct_capture_channel.sv]
`default_nettype none
module mct_capture_channel
  import mct_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // configuration
  input  wire logic [3:0]  capture_mode_select,
  input  wire logic        state_clear,
  input  wire logic        state_set_req,
  // sampled inputs
  input  wire logic        primary_capture_pin,
  input  wire logic        secondary_position_pin,
  input  wire logic [15:0] first_timer,
  // results
  output logic [15:0]      channel_value_reg,
  output logic [15:0]      channel_shadow_reg,
  output logic             channel_state_bit,
  output logic             out_enable_reg
);
  logic [1:0] prim_sync_reg;
  logic [1:0] pos_sync_reg;
  logic       prim_last_reg;
  logic       pos_last_reg;
  logic       p_rise, p_fall, s_rise, s_fall, ev_p, ev_s, multi, hyst;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prim_sync_reg <= 2'h0;
      pos_sync_reg  <= 2'h0;
      prim_last_reg <= 1'b0;
      pos_last_reg  <= 1'b0;
    end else begin
      prim_sync_reg <= {prim_sync_reg[0], primary_capture_pin}; // RULE_23
      pos_sync_reg  <= {pos_sync_reg[0], secondary_position_pin}; // RULE_23
      prim_last_reg <= prim_sync_reg[1];
      pos_last_reg  <= pos_sync_reg[1];
    end
  end

  assign p_rise = prim_sync_reg[1] & ~prim_last_reg; // RULE_23
  assign p_fall = ~prim_sync_reg[1] & prim_last_reg;
  assign s_rise = pos_sync_reg[1] & ~pos_last_reg;
  assign s_fall = ~pos_sync_reg[1] & pos_last_reg;
  assign hyst   = (capture_mode_select == MCT_MODE_HYST);
  assign multi  = (capture_mode_select >= MCT_MODE_RF) && (capture_mode_select != MCT_MODE_NONE); // RULE_02

  always_comb begin
    ev_p = 1'b0;
    ev_s = 1'b0;
    case (capture_mode_select) // RULE_01
      MCT_MODE_RF: begin ev_p = p_rise; ev_s = s_fall; end
      MCT_MODE_FR: begin ev_p = p_fall; ev_s = s_rise; end
      MCT_MODE_RR: begin ev_p = p_rise; ev_s = s_rise; end
      MCT_MODE_FF: begin ev_p = p_fall; ev_s = s_fall; end
      MCT_MODE_AA: begin ev_p = p_rise | p_fall; ev_s = s_rise | s_fall; end
      default: begin ev_p = 1'b0; ev_s = 1'b0; end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      channel_value_reg  <= MCT_RST_VALUE;
      channel_shadow_reg <= MCT_RST_VALUE;
    end else begin
      if (multi && ev_p) channel_value_reg <= first_timer; // RULE_24
      if (multi && ev_s) channel_shadow_reg <= first_timer; // RULE_01
    end
  end

  // set wins over software clear so a coincident event is not lost
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      channel_state_bit <= 1'b0;
    end else if (multi && (ev_p || ev_s)) begin
      channel_state_bit <= 1'b1; // RULE_20
    end else if (hyst && s_fall) begin
      channel_state_bit <= 1'b0; // RULE_03
    end else if (hyst && state_set_req && pos_sync_reg[1]) begin
      channel_state_bit <= 1'b1; // RULE_05
    end else if (state_clear) begin
      channel_state_bit <= 1'b0; // RULE_20
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) out_enable_reg <= 1'b0;
    else if (hyst) out_enable_reg <= pos_sync_reg[1] & channel_state_bit; // RULE_04 RULE_06
    else out_enable_reg <= channel_state_bit;
  end
endmodule // mct_capture_channel
`default_nettype wire

// [tb/mct_sva.sv]
`default_nettype none
module mct_sva #(
  parameter int CHANNELS = 3
) (
  input wire logic                clk,
  input wire logic                rst_n,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic                pready,
  input wire logic [31:0]         prdata,
  input wire logic                pslverr,
  input wire logic [CHANNELS-1:0] channel_out_enable,
  input wire logic                zero_match_signal,
  input wire logic                shadow_transfer_signal
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("ready outside access phase");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_rdata_held: assert property (!$past(psel && !penable && !pwrite) |-> $stable(prdata))
    else $error("read data moved without a read");
  a_rdata_upper: assert property (prdata[31:19] == 13'h0)
    else $error("unused read bits set");
  a_no_slverr: assert property (pslverr == 1'b0)
    else $error("slave error raised");
  a_zero_on_release: assert property (rst_n && !$past(rst_n) |=> zero_match_signal)
    else $error("zero match missing after reset");
  a_quiet_on_release: assert property (rst_n && !$past(rst_n) |->
    channel_out_enable == '0 && !pready && !shadow_transfer_signal)
    else $error("outputs active out of reset");
endmodule // mct_sva
bind mct_top mct_sva #(.CHANNELS(CHANNELS)) u_sva (
  .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .channel_out_enable(channel_out_enable), .zero_match_signal(zero_match_signal),
  .shadow_transfer_signal(shadow_transfer_signal)
);
`default_nettype wire

// [tb/mct_edge_src.sv]
`default_nettype none
module mct_edge_src (
  // clock
  input  wire logic  clk,
  // pads toward the block
  output logic [2:0] pin_pri,
  output logic [2:0] pin_pos
);
  timeunit 1ns;
  timeprecision 1ns;
  // spare channels idle low, like an unused comparator output
  initial begin
    pin_pri = 3'h0;
    pin_pos = 3'h0;
  end
  // pads move just after an edge so the block's synchroniser sees a clean step
  task automatic drive(input logic p, input logic s);
    @(posedge clk);
    pin_pri[0] <= p;
    pin_pos[0] <= s;
  endtask
endmodule // mct_edge_src
`default_nettype wire

// [tb/testbench.sv]
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import mct_pkg::*;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic        fpm, fzm, fdn, hall, pm, zm, st;
  logic [17:0] paddr;
  logic [15:0] ft;
  logic [31:0] pwdata, prdata, q;
  logic [2:0]  pri, pos, ssr, ftc, oe;
  logic [31:0] cv [3] = '{32'h0, 32'h2, 32'h8};
  logic [31:0] ev [3] = '{32'd6, 32'd24, 32'd1536};
  logic [4:0]  pr = 5'b10101;
  logic [4:0]  ps = 5'b00110;
  int          failures = 0;
  int          checked = 0;
  int          cyc = 0;
  mct_top #(.CHANNELS(3)) u_dut (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .primary_capture_pin(pri), .secondary_position_pin(pos), .first_timer(ft),
    .state_set_req(ssr), .ft_compare_event(ftc), .ft_period_match(fpm),
    .ft_zero_match(fzm), .ft_count_down(fdn), .hall_change(hall),
    .channel_out_enable(oe), .period_match_signal(pm), .zero_match_signal(zm),
    .shadow_transfer_signal(st)
  );
  mct_edge_src u_src (.clk(clk), .pin_pri(pri), .pin_pos(pos));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // longest test is two div-256 periods; the ceiling leaves wide margin
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    if (failures == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  // request held until pready is sampled high; read data taken at that edge
  task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {a, 2'b00};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input string n, input logic [15:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(n, q, e);
  endtask
  // edges counted from one period-match rise to the next
  task automatic per(input logic [31:0] e);
    logic [31:0] k;
    k = 0;
    @(posedge clk);
    while (pm === 1'b1) @(posedge clk);
    while (pm !== 1'b1) @(posedge clk);
    while (pm === 1'b1) begin
      @(posedge clk);
      k++;
    end
    while (pm !== 1'b1) begin
      @(posedge clk);
      k++;
    end
    chk("period_len", k, e);
    @(posedge clk);
    if (e == 6) chk("zero_after_match", zm, 1'b1);
  endtask
  task automatic trig(input logic [2:0] e, input logic dn, input logic [1:0] ed, input logic x);
    xfer(1'b1, MCT_OFS_CTRL, {18'h0, ed, 1'b0, e, 8'h00});
    @(posedge clk);
    fdn <= dn;
    ftc <= (e == 3'h1) ? 3'h1 : (e == 3'h2) ? 3'h2 : (e inside {3'h3, 3'h4}) ? 3'h4 : 3'h0;
    fpm <= e == 3'h5;
    fzm <= e == 3'h6;
    hall <= e == 3'h7;
    @(posedge clk);
    ftc <= 3'h0;
    fpm <= 1'b0;
    fzm <= 1'b0;
    hall <= 1'b0;
    xfer(1'b0, MCT_OFS_STATUS, 32'h0);
    chk("run_by_trigger", q[0], x);
    xfer(1'b1, MCT_OFS_CMD, 32'h2);
  endtask
  initial begin
    rst_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, ft, ssr, ftc, fpm, fzm, fdn, hall} = '0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rdc("count_reset", MCT_OFS_COUNT, 32'h0);
    rdc("period_reset", MCT_OFS_PERIOD, 32'h0);
    xfer(1'b1, MCT_OFS_PERIOD, 32'h5);
    rdc("period_shadowed", MCT_OFS_PERIOD, 32'h0);
    xfer(1'b1, MCT_OFS_CMD, 32'h8);
    rdc("period_loaded", MCT_OFS_PERIOD, 32'h5);
    rdc("status_ste", MCT_OFS_STATUS, 32'h6);
    xfer(1'b1, MCT_OFS_COUNT, 32'h3);
    rdc("count_write", MCT_OFS_COUNT, 32'h3);
    xfer(1'b1, MCT_OFS_CMD, 32'h4);
    rdc("count_clear", MCT_OFS_COUNT, 32'h0);
    for (int i = 0; i < 3; i++) begin
      xfer(1'b1, MCT_OFS_CTRL, cv[i]);
      xfer(1'b1, MCT_OFS_CMD, 32'h1);
      per(ev[i]);
      xfer(1'b1, MCT_OFS_CMD, 32'h2);
    end
    xfer(1'b1, MCT_OFS_CTRL, 32'h0);
    xfer(1'b1, MCT_OFS_CMD, 32'h1);
    xfer(1'b1, MCT_OFS_COUNT, 32'hffff);
    xfer(1'b0, MCT_OFS_COUNT, 32'h0);
    chk("count_write_running", q > 5, 1'b0);
    xfer(1'b1, MCT_OFS_CMD, 32'h4);
    xfer(1'b0, MCT_OFS_STATUS, 32'h0);
    chk("clear_keeps_run", q[0], 1'b1);
    xfer(1'b1, MCT_OFS_CMD, 32'h2);
    xfer(1'b0, MCT_OFS_STATUS, 32'h0);
    chk("run_cleared", q[0], 1'b0);
    xfer(1'b1, MCT_OFS_CTRL, 32'h10);
    xfer(1'b1, MCT_OFS_CMD, 32'h4);
    xfer(1'b1, MCT_OFS_CMD, 32'h1);
    repeat (30) @(posedge clk);
    xfer(1'b0, MCT_OFS_STATUS, 32'h0);
    chk("single_shot_stop", q[0], 1'b0);
    rdc("single_shot_count", MCT_OFS_COUNT, 32'h0);
    chk("transfer_stopped", st, 1'b1);
    for (int e = 1; e < 8; e++) trig(e[2:0], 1'b0, MCT_TED_UP, 1'b1);
    trig(3'h1, 1'b1, MCT_TED_UP, 1'b0);
    trig(3'h1, 1'b1, MCT_TED_DOWN, 1'b1);
    trig(3'h1, 1'b1, MCT_TED_ANY, 1'b1);
    trig(MCT_TEC_NONE, 1'b0, MCT_TED_ANY, 1'b0);
    for (int k = 0; k < 5; k++) begin
      xfer(1'b1, MCT_OFS_CHMODE, {28'h0, MCT_MODE_NONE});
      u_src.drive(!pr[k], !ps[k]);
      repeat (6) @(posedge clk);
      xfer(1'b1, MCT_OFS_CHCLR, 32'h1);
      xfer(1'b1, MCT_OFS_CHMODE, 32'ha + k);
      ft <= 16'h1000 + k[15:0];
      u_src.drive(pr[k], !ps[k]);
      repeat (6) @(posedge clk);
      ft <= 16'h2000 + k[15:0];
      u_src.drive(pr[k], ps[k]);
      repeat (6) @(posedge clk);
      rdc("capture_value", MCT_OFS_CHVAL0, 32'h1000 + k);
      rdc("capture_shadow", MCT_OFS_CHSHD0, 32'h2000 + k);
      xfer(1'b0, MCT_OFS_CHMODE, 32'h0);
      chk("capture_state", q[16], 1'b1);
    end
    xfer(1'b1, MCT_OFS_CHMODE, {28'h0, MCT_MODE_NONE});
    xfer(1'b1, MCT_OFS_CHCLR, 32'h1);
    ft <= 16'h3000;
    u_src.drive(1'b0, 1'b1);
    repeat (6) @(posedge clk);
    rdc("no_capture", MCT_OFS_CHVAL0, 32'h1004);
    xfer(1'b0, MCT_OFS_CHMODE, 32'h0);
    chk("no_capture_state", q[16], 1'b0);
    xfer(1'b1, MCT_OFS_CHMODE, {28'h0, MCT_MODE_HYST});
    xfer(1'b1, MCT_OFS_CHCLR, 32'h1);
    ssr <= 3'h1;
    repeat (4) @(posedge clk);
    ssr <= 3'h0;
    repeat (4) @(posedge clk);
    chk("hyst_set", oe[0], 1'b1);
    u_src.drive(1'b0, 1'b0);
    repeat (6) @(posedge clk);
    chk("hyst_off", oe[0], 1'b0);
    xfer(1'b0, MCT_OFS_CHMODE, 32'h0);
    chk("hyst_clear", q[16], 1'b0);
    ssr <= 3'h1;
    repeat (4) @(posedge clk);
    ssr <= 3'h0;
    xfer(1'b0, MCT_OFS_CHMODE, 32'h0);
    chk("hyst_blocked", q[16], 1'b0);
    u_src.drive(1'b0, 1'b1);
    repeat (6) @(posedge clk);
    chk("hyst_follow", oe[0], 1'b0);
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
